/* File: core/tfc_pkg.sv */
// Purpose: Shared constants and types for the transmit format control block
// Assumes: One 100 MHz clock; framer logic on the same clock
// Notes:   Register byte address is four times the register index
//
// Summary of operation
// [RULE1] Bit 15 takes all overhead externally in STS and G.832 modes.
// [RULE2] Bit 14 forces an all-zeros far-end block error field.
// [RULE3] Bit 13 forces an all-ones far-end block error field.
// [RULE4] Forced block error patterns leave local parity status and counters alone.
// [RULE5] Both block error forcing bits work in every line mode.
// [RULE6] Bits 12-10 pick the parity field corrupted with the pattern register.
// [RULE7] Codes 010, 011, 100 corrupt one line parity octet each, mode permitting.
// [RULE8] 001 B1, 101 B3, 111 all B2 octets; 000 and 110 nothing.
// [RULE9] The insertion field clears to zero once the error has been sent.
// [RULE10] Alarm bits 9-4 at zero send no alarm; each set bit sends one. The code masks off the alarm bits the line mode does not use.
// [RULE11] In STS-3c mode alarm bit 4 sends line AIS.
// [RULE12] Overhead disable bits all zero means all overhead generated internally.
// [RULE13] A disabled overhead field goes out as zeros; coverage depends on mode.
// [RULE14] STS modes: bits 4..9 line AIS, line FERF, path yellow, path FERF, AIS, unequipped.
// [RULE15] Internal DS3 57-octet: 7 G1 yellow, 6 X-bit yellow, 5 idle, 4 AIS.
// [RULE16] STS overhead disables: 3 A1/A2, 2 B1-B3, 1 H1-H4, 0 C1/C2.
// [RULE17] One line format setting governs both directions and all mappings.
// [RULE18] One nonzero code write corrupts exactly one following frame.
`default_nettype none

package tfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned IDX_STATUS = 0;
  localparam int unsigned IDX_TFC = 1;
  localparam int unsigned IDX_ERRPAT = 2;
  localparam logic [3:0] ADDR_STATUS = 4'(IDX_STATUS * 4);
  localparam logic [3:0] ADDR_TFC = 4'(IDX_TFC * 4);
  localparam logic [3:0] ADDR_ERRPAT = 4'(IDX_ERRPAT * 4);
  localparam logic [15:0] TFC_RST = 16'h0000;
  localparam logic [7:0] ERRPAT_RST = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned B_EXT_OH = 15;
  localparam int unsigned B_FEBE_ZERO = 14;
  localparam int unsigned B_FEBE_ONES = 13;
  localparam int unsigned ERR_MSB = 12;
  localparam int unsigned ERR_LSB = 10;
  localparam int unsigned ALM_MSB = 9;
  localparam int unsigned ALM_LSB = 4;
  localparam int unsigned OHD_MSB = 3;
  localparam int unsigned OHD_LSB = 0;

  // ----------------------------------------------------------------
  // Error insertion codes and line modes
  // ----------------------------------------------------------------
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_B1 = 3'h1;
  localparam logic [2:0] ERR_B2_HI = 3'h2;
  localparam logic [2:0] ERR_B2_MID = 3'h3;
  localparam logic [2:0] ERR_B2_LO = 3'h4;
  localparam logic [2:0] ERR_B3 = 3'h5;
  localparam logic [2:0] ERR_NONE_ALT = 3'h6;
  localparam logic [2:0] ERR_B2_ALL = 3'h7;
  localparam logic [2:0] PHY_DS3 = 3'h2;
  localparam logic [2:0] PHY_E3_G751 = 3'h3;
  localparam logic [2:0] PHY_E3_G832 = 3'h4;
  localparam logic [2:0] PHY_E4_G832 = 3'h5;
  localparam logic [2:0] PHY_STS1 = 3'h6;
  localparam logic [2:0] PHY_STS3C = 3'h7;

  typedef enum logic {
    TFC_IDLE = 1'b0,
    TFC_SEND = 1'b1
  } tfc_state_t;

  // Line configuration shared with the receive side
  typedef struct packed {
    logic [2:0] phy;
    logic hec_align;
    logic ext_framer;
  } tfc_cfg_t;

  // Controls handed to the transmit framer
  typedef struct packed {
    logic ext_oh;
    logic febe_zero;
    logic febe_ones;
    logic [5:0] alarm;
    logic [3:0] oh_dis;
    logic err_b1;
    logic [2:0] err_b2;
    logic err_b3;
    logic [7:0] err_pat;
  } tfc_ctl_t;

endpackage : tfc_pkg

`default_nettype wire

/* File: core/tfc_map.sv */
// Purpose: Map register fields onto framer controls for the active line mode
// Assumes: Purely combinational; caller registers the result
// Notes:   Bits a mode leaves unused are masked to zero
`default_nettype none

module tfc_map (
  input wire tfc_pkg::tfc_cfg_t cfg_i,
  input wire logic [15:0] tfc_i,
  input wire logic [7:0] pat_i,
  input wire logic send_i,
  input wire logic [2:0] code_i,
  output tfc_pkg::tfc_ctl_t ctl_o
);

  // Alarm bits that the mode uses, bit 0 is alarm control 4
  // [RULE14] STS alarm map
  // [RULE15] DS3 alarm map
  function automatic logic [5:0] alm_mask(input tfc_pkg::tfc_cfg_t c);
    logic p57;
    p57 = !c.hec_align;
    if (c.phy[2] && c.phy[1])
      alm_mask = 6'h3f;
    else if (c.phy[2])
      alm_mask = 6'h07;
    else if (c.phy == tfc_pkg::PHY_DS3 && !c.ext_framer)
      alm_mask = p57 ? 6'h0f : 6'h07;
    else if (c.phy == tfc_pkg::PHY_E3_G751 && !c.ext_framer)
      alm_mask = 6'h0b;
    else if (p57)
      alm_mask = 6'h08;
    else
      alm_mask = 6'h00;
  endfunction : alm_mask

  // Overhead disable bits that the mode uses
  // [RULE16] STS overhead disables
  function automatic logic [3:0] ohd_mask(input tfc_pkg::tfc_cfg_t c);
    if (c.phy[2] && !c.phy[1])
      ohd_mask = 4'he;
    else if (c.phy[2] || !c.hec_align)
      ohd_mask = 4'hf;
    else
      ohd_mask = 4'h0;
  endfunction : ohd_mask

  logic sts;
  logic sts3;
  assign sts = cfg_i.phy[2] && cfg_i.phy[1];
  assign sts3 = cfg_i.phy == tfc_pkg::PHY_STS3C;

  // Field mapping, all from one line format setting
  always_comb begin
    // [RULE1] external overhead gating
    ctl_o.ext_oh = tfc_i[tfc_pkg::B_EXT_OH] && cfg_i.phy[2];
    // [RULE3] ones wins tie
    ctl_o.febe_ones = tfc_i[tfc_pkg::B_FEBE_ONES];
    // [RULE5] no mode gating
    // [RULE2] zeros pattern force
    ctl_o.febe_zero = tfc_i[tfc_pkg::B_FEBE_ZERO] && !tfc_i[tfc_pkg::B_FEBE_ONES];
    // [RULE11] STS-3c line AIS
    // [RULE10] per mode alarms
    ctl_o.alarm = tfc_i[tfc_pkg::ALM_MSB:tfc_pkg::ALM_LSB] & alm_mask(cfg_i);
    // [RULE12] zero means internal
    // [RULE13] disabled fields zeroed
    ctl_o.oh_dis = tfc_i[tfc_pkg::OHD_MSB:tfc_pkg::OHD_LSB] & ohd_mask(cfg_i);
    ctl_o.err_pat = pat_i;
    // [RULE8] code to field
    ctl_o.err_b1 = send_i && code_i == tfc_pkg::ERR_B1;
    ctl_o.err_b3 = send_i && sts && code_i == tfc_pkg::ERR_B3;
    // [RULE7] B2 octet select
    ctl_o.err_b2[2] = send_i && sts3 &&
                      (code_i == tfc_pkg::ERR_B2_HI || code_i == tfc_pkg::ERR_B2_ALL);
    ctl_o.err_b2[1] = send_i && sts3 &&
                      (code_i == tfc_pkg::ERR_B2_MID || code_i == tfc_pkg::ERR_B2_ALL);
    ctl_o.err_b2[0] = send_i && ((sts && code_i == tfc_pkg::ERR_B2_LO) ||
                      (sts3 && code_i == tfc_pkg::ERR_B2_ALL));
  end

endmodule : tfc_map

`default_nettype wire

/* File: core/tfc_top.sv */
// Purpose: Transmit format control register with Avalon-MM access
// Assumes: Framer and line configuration share clock_i; frame_start_i is a pulse
// Notes:   One wait state on every bus access; ce_i low freezes all state except the reset release flops
`default_nettype none

module tfc_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire tfc_pkg::tfc_cfg_t cfg_i,
  input wire logic frame_start_i,
  output tfc_pkg::tfc_ctl_t ctl_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Release is synchronous so no flop sees a runt reset edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic req;
  logic tfc_wr;
  logic pat_wr;
  logic [15:0] tfc_r;
  logic [15:0] tfc_nxt;
  logic [7:0] pat_r;
  tfc_pkg::tfc_state_t state_r;
  logic [2:0] code_r;
  logic clr;

  assign req = avs_read_i || avs_write_i;
  // Every access stalls one cycle so read data can come from a flop
  assign avs_waitrequest_o = req && !ack_r;
  assign tfc_wr = avs_write_i && ack_r && avs_address_i == tfc_pkg::ADDR_TFC;
  assign pat_wr = avs_write_i && ack_r && avs_address_i == tfc_pkg::ADDR_ERRPAT;

  // Acknowledge one cycle after the request appears
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= req && !ack_r;
    end
  end

  // Read data captured in the stall cycle; unmapped reads give zero
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && !ack_r) begin
      unique case (avs_address_i)
        tfc_pkg::ADDR_STATUS: avs_readdata_o <= {28'h0000000, code_r, state_r};
        tfc_pkg::ADDR_TFC: avs_readdata_o <= {16'h0000, tfc_r};
        tfc_pkg::ADDR_ERRPAT: avs_readdata_o <= {24'h000000, pat_r};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Byte-lane merge of a software write
  always_comb begin
    tfc_nxt = tfc_r;
    if (avs_byteenable_i[0]) begin
      tfc_nxt[7:0] = avs_writedata_i[7:0];
    end
    if (avs_byteenable_i[1]) begin
      tfc_nxt[15:8] = avs_writedata_i[15:8];
    end
  end

  // A write landing on the clear cycle wins: it is a fresh request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tfc_r <= tfc_pkg::TFC_RST;
    end else if (ce_i) begin
      if (tfc_wr) begin
        tfc_r <= tfc_nxt;
      // [RULE9] self clearing field
      end else if (clr) begin
        tfc_r[tfc_pkg::ERR_MSB:tfc_pkg::ERR_LSB] <= tfc_pkg::ERR_NONE;
      end
    end
  end

  // [RULE6] pattern for corruption
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pat_r <= tfc_pkg::ERRPAT_RST;
    end else if (ce_i && pat_wr && avs_byteenable_i[0]) begin
      pat_r <= avs_writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Error insertion sequencing
  // ----------------------------------------------------------------
  logic [2:0] req_code;
  assign req_code = tfc_r[tfc_pkg::ERR_MSB:tfc_pkg::ERR_LSB];
  // Insertion ends at the start of the frame after the errored one
  assign clr = state_r == tfc_pkg::TFC_SEND && frame_start_i;

  // [RULE18] one frame per request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tfc_pkg::TFC_IDLE;
      code_r <= tfc_pkg::ERR_NONE;
    end else if (ce_i) begin
      unique case (state_r)
        tfc_pkg::TFC_IDLE: begin
          if (frame_start_i && req_code != tfc_pkg::ERR_NONE) begin
            state_r <= tfc_pkg::TFC_SEND;
            code_r <= req_code;
          end
        end
        tfc_pkg::TFC_SEND: begin
          if (frame_start_i) begin
            state_r <= tfc_pkg::TFC_IDLE;
            code_r <= tfc_pkg::ERR_NONE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Framer controls
  // ----------------------------------------------------------------
  tfc_pkg::tfc_ctl_t ctl_nxt;

  // [RULE17] single line format
  tfc_map u_map (
    .cfg_i(cfg_i),
    .tfc_i(tfc_r),
    .pat_i(pat_r),
    .send_i(state_r == tfc_pkg::TFC_SEND),
    .code_i(code_r),
    .ctl_o(ctl_nxt)
  );

  // Registered so the framer sees glitch-free controls.
  // [RULE4] no path to local parity counters
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_o <= '0;
    end else if (ce_i) begin
      ctl_o <= ctl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_arm;
    ce_i && state_r == tfc_pkg::TFC_IDLE && frame_start_i && req_code != tfc_pkg::ERR_NONE;
  endsequence

  sequence s_done;
    ce_i && state_r == tfc_pkg::TFC_SEND && frame_start_i && !tfc_wr;
  endsequence

  property p_ext_oh;
    @(posedge clock_i) disable iff (!rst_n)
    ce_i ##1 1'b1 |-> ctl_o.ext_oh == $past(tfc_r[15] && cfg_i.phy[2]);
  endproperty
  a_ext_oh: assert property (p_ext_oh) // [RULE1]
    else $error("external overhead control wrong for mode");

  property p_febe_zero;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && tfc_r[14] && !tfc_r[13]) |=> ctl_o.febe_zero && !ctl_o.febe_ones;
  endproperty
  a_febe_zero: assert property (p_febe_zero) // [RULE2]
    else $error("all-zeros block error force not applied");

  property p_febe_ones;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && tfc_r[13]) |=> ctl_o.febe_ones && !ctl_o.febe_zero;
  endproperty
  a_febe_ones: assert property (p_febe_ones) // [RULE3]
    else $error("all-ones block error force not applied");

  property p_one_frame;
    @(posedge clock_i) disable iff (!rst_n)
    s_arm |=> state_r == tfc_pkg::TFC_SEND && code_r == $past(req_code);
  endproperty
  a_one_frame: assert property (p_one_frame) // [RULE18]
    else $error("error insertion did not start at frame start");

  property p_clear;
    @(posedge clock_i) disable iff (!rst_n)
    s_done |=> tfc_r[12:10] == 3'h0 && state_r == tfc_pkg::TFC_IDLE;
  endproperty
  a_clear: assert property (p_clear) // [RULE9]
    else $error("insertion field not cleared after the errored frame");

  property p_b2_hi;
    @(posedge clock_i) disable iff (!rst_n)
    (state_r == tfc_pkg::TFC_SEND && code_r == 3'h2) |->
      ctl_nxt.err_b2 == ((cfg_i.phy == 3'h7) ? 3'h4 : 3'h0);
  endproperty
  a_b2_hi: assert property (p_b2_hi) // [RULE7]
    else $error("high B2 octet selection wrong");

  property p_no_err;
    @(posedge clock_i) disable iff (!rst_n)
    (state_r == tfc_pkg::TFC_IDLE || code_r == 3'h6) |->
      !ctl_nxt.err_b1 && !ctl_nxt.err_b3 && ctl_nxt.err_b2 == 3'h0;
  endproperty
  a_no_err: assert property (p_no_err) // [RULE8]
    else $error("error inserted without a live request");

  property p_alarm_off;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && tfc_r[9:4] == 6'h00) |=> ctl_o.alarm == 6'h00;
  endproperty
  a_alarm_off: assert property (p_alarm_off) // [RULE10]
    else $error("alarm sent with all alarm bits clear");

  property p_line_ais;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && cfg_i.phy == 3'h7 && tfc_r[4]) |=> ctl_o.alarm[0];
  endproperty
  a_line_ais: assert property (p_line_ais) // [RULE11]
    else $error("line AIS not sent in STS-3c mode");

  property p_oh_internal;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && tfc_r[3:0] == 4'h0) |=> ctl_o.oh_dis == 4'h0;
  endproperty
  a_oh_internal: assert property (p_oh_internal) // [RULE12]
    else $error("overhead disabled with all disable bits clear");

  property p_sts_oh;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && cfg_i.phy[2] && cfg_i.phy[1]) |=> ctl_o.oh_dis == $past(tfc_r[3:0]);
  endproperty
  a_sts_oh: assert property (p_sts_oh) // [RULE16]
    else $error("STS overhead disable bits not passed through");

  property p_bus_answer;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && req && avs_waitrequest_o) ##1 (ce_i && req) |-> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access stalled more than one cycle");

endmodule : tfc_top

`default_nettype wire

/* File: verif/tfc_top_tb.sv */
// Purpose: Self-checking bench for the transmit format control block
// Assumes: One clock; the bench drives the bus, line config and frame pulses
// Notes:   All register traffic goes through one Avalon-MM request task
`default_nettype none

module tfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_i;
  logic rst_b_i;
  logic ce_i;
  logic [3:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  tfc_pkg::tfc_cfg_t cfg_i;
  logic frame_start_i;
  tfc_pkg::tfc_ctl_t ctl_o;
  int n_fail;
  int n_tests;
  logic [2:0] ph;
  logic [2:0] code;

  // Clock enable driven by the bench; one test freezes the block
  tfc_top dut (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .cfg_i(cfg_i),
    .frame_start_i(frame_start_i),
    .ctl_o(ctl_o)
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Tasks and helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {~d, d}; // Upper lanes carry junk that must be ignored
    avs_byteenable_i <= be;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr

  // Read compare
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'hf, q);
    n_tests++;
    if (q !== {16'h0000, e}) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, {16'h0000, e}, q);
    end
  endtask : rd_chk

  // Control output compare; the pattern byte only when full is set
  task automatic chk_ctl(input string what, input tfc_pkg::tfc_ctl_t e, input bit full);
    logic [25:0] m;
    #1;
    m = full ? 26'h3ffffff : 26'h3ffff00;
    n_tests++;
    if (((ctl_o ^ e) & m) !== 26'h0000000) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e & m, ctl_o & m);
    end
  endtask : chk_ctl

  function automatic tfc_pkg::tfc_cfg_t cf(input logic [2:0] p, input logic hec);
    cf = {p, hec, 1'b0};
  endfunction : cf

  function automatic tfc_pkg::tfc_ctl_t mk(input logic [2:0] f, input logic [5:0] al,
                                            input logic [3:0] oh, input logic [4:0] er);
    tfc_pkg::tfc_ctl_t e;
    e = '0;
    {e.ext_oh, e.febe_zero, e.febe_ones} = f;
    e.alarm = al;
    e.oh_dis = oh;
    {e.err_b1, e.err_b2, e.err_b3} = er;
    e.err_pat = 8'h5a;
    return e;
  endfunction : mk

  // Expected {b1, b2 hi/mid/lo, b3} for a code in a line mode
  function automatic logic [4:0] err_exp(input logic [2:0] c, input logic [2:0] p);
    logic s3;
    logic sts;
    s3 = (p == tfc_pkg::PHY_STS3C);
    sts = s3 || (p == tfc_pkg::PHY_STS1);
    case (c)
      3'h1: err_exp = 5'h10;
      3'h2: err_exp = s3 ? 5'h08 : 5'h00;
      3'h3: err_exp = s3 ? 5'h04 : 5'h00;
      3'h4: err_exp = sts ? 5'h02 : 5'h00;
      3'h5: err_exp = sts ? 5'h01 : 5'h00;
      3'h7: err_exp = s3 ? 5'h0e : 5'h00;
      default: err_exp = 5'h00;
    endcase
  endfunction : err_exp

  // Set line mode, write the register, check the framer controls
  task automatic mode(input tfc_pkg::tfc_cfg_t c, input logic [15:0] d,
                      input tfc_pkg::tfc_ctl_t e);
    @(posedge clock_i);
    cfg_i <= c;
    wr(tfc_pkg::ADDR_TFC, d);
    repeat (2) @(posedge clock_i);
    chk_ctl("ctl fields", e, 1'b0);
  endtask : mode

  // One-cycle frame start, then let the controls settle
  task automatic frame();
    @(posedge clock_i);
    frame_start_i <= 1'b1;
    @(posedge clock_i);
    frame_start_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : frame

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'h0;
    cfg_i = '0;
    frame_start_i = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    // Reset values, read-only and unmapped places, byte lanes
    rd_chk("status", tfc_pkg::ADDR_STATUS, 16'h0000);
    rd_chk("tfc reset", tfc_pkg::ADDR_TFC, tfc_pkg::TFC_RST);
    rd_chk("pattern reset", tfc_pkg::ADDR_ERRPAT, {8'h00, tfc_pkg::ERRPAT_RST});
    rd_chk("unmapped", 4'hc, 16'h0000);
    wr(4'hc, 16'hffff);
    wr(tfc_pkg::ADDR_STATUS, 16'hffff);
    rd_chk("status ro", tfc_pkg::ADDR_STATUS, 16'h0000);
    rd_chk("tfc untouched", tfc_pkg::ADDR_TFC, 16'h0000);
    wr(tfc_pkg::ADDR_TFC, 16'hfbcd, 4'h1);
    rd_chk("tfc lane 0", tfc_pkg::ADDR_TFC, 16'h00cd);
    $display("test registers done");
    // Mode mappings of force, alarm and overhead disable bits
    mode(cf(tfc_pkg::PHY_STS3C, 1'b1), 16'h0000, mk(3'h0, 6'h00, 4'h0, 5'h00));
    mode(cf(tfc_pkg::PHY_STS3C, 1'b1), 16'he3ff, mk(3'h5, 6'h3f, 4'hf, 5'h00));
    mode(cf(tfc_pkg::PHY_STS3C, 1'b1), 16'h0010, mk(3'h0, 6'h01, 4'h0, 5'h00));
    mode(cf(tfc_pkg::PHY_STS1, 1'b1), 16'h43c5, mk(3'h2, 6'h3c, 4'h5, 5'h00));
    mode(cf(tfc_pkg::PHY_DS3, 1'b0), 16'hc3f5, mk(3'h2, 6'h0f, 4'h5, 5'h00));
    mode(cf(tfc_pkg::PHY_E3_G832, 1'b1), 16'h83ff, mk(3'h4, 6'h07, 4'he, 5'h00));
    mode(cf(tfc_pkg::PHY_STS3C, 1'b1), 16'h200f, mk(3'h1, 6'h00, 4'hf, 5'h00));
    // Modes with partial or no alarm and disable use, external bit passed in E4 G.832 and gated in E3 G.751
    mode(cf(tfc_pkg::PHY_E4_G832, 1'b1), 16'h8000, mk(3'h4, 6'h00, 4'h0, 5'h00));
    mode(cf(tfc_pkg::PHY_E3_G751, 1'b0), 16'h83f3, mk(3'h0, 6'h0b, 4'h3, 5'h00));
    mode(cf(3'h0, 1'b1), 16'h43ff, mk(3'h2, 6'h00, 4'h0, 5'h00));
    $display("test mappings done");
    // Clock enable low: a frame start must not arm insertion
    mode(cf(tfc_pkg::PHY_STS3C, 1'b1), 16'h0400, mk(3'h0, 6'h00, 4'h0, 5'h00));
    @(posedge clock_i);
    ce_i <= 1'b0;
    frame();
    ce_i <= 1'b1;
    rd_chk("frozen status", tfc_pkg::ADDR_STATUS, 16'h0000);
    rd_chk("frozen field", tfc_pkg::ADDR_TFC, 16'h0400);
    $display("test clock enable done");
    // Error insertion: every nonzero code, three line modes, one frame each
    wr(tfc_pkg::ADDR_ERRPAT, 16'h005a);
    rd_chk("pattern", tfc_pkg::ADDR_ERRPAT, 16'h005a);
    for (int m = 0; m < 3; m++) begin
      for (int c = 1; c < 8; c++) begin
        ph = (m == 0) ? tfc_pkg::PHY_STS3C :
             (m == 1) ? tfc_pkg::PHY_STS1 : tfc_pkg::PHY_E3_G832;
        code = 3'(c);
        mode(cf(ph, 1'b1), {3'h0, code, 10'h000}, mk(3'h0, 6'h00, 4'h0, 5'h00));
        frame();
        chk_ctl("err sent", mk(3'h0, 6'h00, 4'h0, err_exp(code, ph)), 1'b0);
        if (err_exp(code, ph) != 5'h00) begin
          chk_ctl("err pattern", mk(3'h0, 6'h00, 4'h0, err_exp(code, ph)), 1'b1);
        end
        rd_chk("status busy", tfc_pkg::ADDR_STATUS, {12'h000, code, 1'b1});
        frame();
        chk_ctl("err over", mk(3'h0, 6'h00, 4'h0, 5'h00), 1'b0);
        rd_chk("field cleared", tfc_pkg::ADDR_TFC, 16'h0000);
      end
    end
    $display("test error insertion done");
    end_of_test();
  end

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end

endmodule : tfc_top_tb

`default_nettype wire
